// *** logic/irsc_pkg.sv ***
// package of the infrared transceiver control serial slave: link codes, field layout, reset values and counts.
// assumes one system clock domain and one link domain clocked by the master's serial clock.
package irsc_pkg;

    // slave addresses in the command byte
    localparam logic [2:0] ADDR_INDIV = 3'h2;
    localparam logic [2:0] ADDR_BCAST = 3'h7;

    // command byte layout, sent lsb first after its start bit
    localparam int CMD_ADDR_LSB = 0;
    localparam int CMD_READ_BIT = 3;
    localparam int CMD_IDX_LSB = 4;

    // register indexes
    localparam logic [3:0] IDX_CTRL0 = 4'h0;
    localparam logic [3:0] IDX_CTRL1 = 4'h1;
    localparam logic [3:0] IDX_CTRL2 = 4'h2;
    localparam logic [3:0] IDX_RESET = 4'hd;

    // control register 0 fields, plus the power field position of control register 2
    localparam int C0_POWER_BIT = 0;
    localparam int C0_OEN_BIT = 1;
    localparam int C0_LED_BIT = 2;
    localparam int C0_ACK_PULSE_ENABLE_BIT = 4;
    localparam int C0_WIDTH = 5;
    localparam int C2_POWER_LSB = 4;

    // start bit levels: write line rests low, read line rests high
    localparam logic TX_START_LEVEL = 1'b1;
    localparam logic RX_START_LEVEL = 1'b0;
    localparam logic RX_REST_LEVEL = 1'b1;

    // counts in serial clock cycles
    localparam logic [4:0] PRIME_CYCLES = 5'h1e;
    localparam logic [3:0] RESP_GAP = 4'h4;
    localparam logic [3:0] BYTE_BITS = 4'h8;

    typedef enum logic [2:0] {
        ST_PRIME = 3'h0,
        ST_IDLE = 3'h1,
        ST_CMD = 3'h3,
        ST_DATA = 3'h2,
        ST_GAP = 3'h6,
        ST_RESP = 3'h7,
        ST_ACK = 3'h5
    } irsc_state_type;

    typedef struct packed {
        logic [C0_WIDTH-1:0] ctrl0;
        logic [7:0] ctrl1;
        logic [3:0] power;
    } irsc_cfg_type;

    localparam irsc_cfg_type CFG_RESET = '{ctrl0: 5'h00, ctrl1: 8'h00, power: 4'h7};

    typedef struct packed {
        logic meta;
        logic stable;
    } irsc_sync_type;

endpackage

// *** logic/irsc_sync.sv ***
// two-flop level synchroniser.
// assumes the input is a level that holds for several destination clock cycles.
`timescale 1ns/10ps
module irsc_sync
    import irsc_pkg::*;
(
    // clock
    input wire logic clk_i,
    // level in and out
    input wire logic d_i,
    output logic q_o
);
    import irsc_pkg::*;

    irsc_sync_type q, d;

    // no reset here: it also carries the reset itself into the link domain
    always_comb begin
        d = q;
        d.meta = d_i;
        d.stable = q.meta;
    end

    always_ff @(posedge clk_i) begin
        q <= d;
    end

    assign q_o = q.stable;

endmodule

// *** logic/irsc_slave.sv ***
// control serial slave of an infrared transceiver: command shift, response, ack pulse and led/photodiode blanking.
// assumes the master owns the serial clock, stops it when idle and primes it after power-up;
// the system clock runs at 200 MHz and is unrelated to the serial clock.
`timescale 1ns/10ps

// How it works
// R01: master starts everything; slave only answers
// R02: command always; response only for reads
// R03: response starts four cycles after command
// R04: only master drives clock, still when idle
// R05: bytes follow back to back
// R06: every byte goes lsb first
// R07: data captured on serial clock rise
// R08: master changes write line on fall
// R09: slave changes read line on rise
// R10: one start bit before every byte
// R11: idle write line passes to led
// R12: first rising edge blanks the led
// R13: last command cycle re-enables the led
// R14: no clock edges between commands
// R15: photodiode cut off during read response
// R16: addressed slave drives read data always
// R17: master primes 30 clocks with line low
// R18: only one receiver output enabled
// R19: ack enable cuts photodiode, pulses low
// R20: master holds write line high during read
// R21: read end found from write line
// R22: write line rests low, read high
// R23: same-address slaves get separate clocks
// R24: answer to address 010 and 111
// R25: configuration applied after command completes
// R26: ack only individual writes with output enabled
// R27: link logic on serial clock, reset cleanly
// R28: ignore other addresses, no response
module irsc_slave
    import irsc_pkg::*;
(
    // system clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // serial clock from the master
    input wire logic link_clk_i,
    // shared write line and led drive
    input wire logic tx_and_write_data_line_i,
    output logic ir_transmit_line_o,
    // photodiode signal and shared read line
    input wire logic ir_receive_line_i,
    output logic rx_and_read_data_line_o,
    output logic rx_and_read_data_line_oe_o,
    // applied configuration
    output logic power_mode_o,
    output logic receiver_output_enable_o,
    output logic led_enable_o,
    output logic ack_pulse_enable_o,
    output logic [7:0] ir_mode_o,
    output logic [3:0] tx_power_o,
    // link status
    output logic link_ready_o
);
    import irsc_pkg::*;

    typedef struct packed {
        irsc_state_type state;
        logic [4:0] cnt;
        logic [7:0] shift;
        logic [7:0] cmd;
        logic hit;
        logic indiv;
        logic led_block;
        logic drive;
        logic drive_oe;
        logic drive_active;
        irsc_cfg_type cfg;
        logic cfg_toggle;
        logic ready;
    } irsc_link_type;

    typedef struct packed {
        irsc_cfg_type cfg;
        logic toggle_seen;
    } irsc_sys_type;

    irsc_link_type lq, ld;
    irsc_sys_type sq, sd;
    logic link_rst;
    logic toggle_sync;
    logic photo_sync;
    logic tx;
    logic [7:0] byte_in;

    function automatic logic addr_match(input logic [2:0] addr);
        addr_match = (addr == ADDR_INDIV) || (addr == ADDR_BCAST);
    endfunction

    function automatic logic [7:0] read_value(input logic [3:0] idx, input irsc_cfg_type cfg);
        case (idx)
            IDX_CTRL0: read_value = {{(8 - C0_WIDTH){1'b0}}, cfg.ctrl0};
            IDX_CTRL1: read_value = cfg.ctrl1;
            IDX_CTRL2: read_value = {cfg.power, 4'h0};
            default: read_value = 8'h00;
        endcase
    endfunction

    // judged on the settings held before this command, so a write that sets the enable is not itself answered
    function automatic logic ack_due(input logic indiv, input irsc_cfg_type cfg);
        ack_due = indiv && cfg.ctrl0[C0_ACK_PULSE_ENABLE_BIT] && cfg.ctrl0[C0_OEN_BIT];
    endfunction

    // reset reaches the link domain only while the master clocks it; priming supplies those edges
    irsc_sync u_rst_sync (
        .clk_i(link_clk_i),
        .d_i(rst_i),
        .q_o(link_rst)
    );

    // photodiode output is asynchronous to everything here
    irsc_sync u_photo_sync (
        .clk_i(clk_i),
        .d_i(ir_receive_line_i),
        .q_o(photo_sync)
    );

    // configuration arrives as a toggle; the word itself stays put for a whole command
    irsc_sync u_cfg_sync (
        .clk_i(clk_i),
        .d_i(lq.cfg_toggle),
        .q_o(toggle_sync)
    );

    // ready leaves the link domain from its own flop, never as a state decode that could glitch;
    // the system side sees it two or three clocks late, which only delays a status bit
    irsc_sync u_ready_sync (
        .clk_i(clk_i),
        .d_i(lq.ready),
        .q_o(link_ready_o)
    );

    assign tx = tx_and_write_data_line_i;
    assign byte_in = {tx, lq.shift[7:1]}; // [R06]

    // link domain: every step below happens on a rising serial clock edge
    always_comb begin
        ld = lq;
        if (link_rst) begin // [R27]
            ld.state = ST_PRIME;
            ld.cnt = 5'h00;
            ld.shift = 8'h00;
            ld.cmd = 8'h00;
            ld.hit = 1'b0;
            ld.indiv = 1'b0;
            ld.led_block = 1'b1;
            ld.drive = RX_REST_LEVEL;
            ld.drive_oe = 1'b0;
            ld.drive_active = 1'b0;
            ld.cfg = CFG_RESET;
            ld.cfg_toggle = 1'b0;
            // ready drops with reset, so the priming must be received again
            ld.ready = 1'b0;
        end else begin
            unique case (lq.state)
                ST_PRIME: begin
                    // a high write line restarts the priming count
                    if (tx) begin
                        ld.cnt = 5'h00;
                    end else if (lq.cnt == PRIME_CYCLES - 5'h01) begin
                        ld.cnt = 5'h00;
                        ld.state = ST_IDLE;
                        ld.led_block = 1'b0;
                        // priming done: commands are accepted from the next edge on
                        ld.ready = 1'b1; // [R27]
                    end else begin
                        ld.cnt = lq.cnt + 5'h01;
                    end
                end
                ST_IDLE: begin
                    // any edge here blanks the led, even a stray one between commands
                    ld.led_block = 1'b1; // [R12] [R14]
                    ld.cnt = 5'h00;
                    if (tx == TX_START_LEVEL) begin // [R01] [R10]
                        ld.state = ST_CMD;
                    end
                end
                ST_CMD: begin
                    ld.shift = byte_in; // [R07]
                    ld.cnt = lq.cnt + 5'h01;
                    if (lq.cnt == 5'(BYTE_BITS - 4'h1)) begin
                        ld.cmd = byte_in;
                        ld.hit = addr_match(byte_in[CMD_ADDR_LSB +: 3]); // [R24]
                        ld.indiv = byte_in[CMD_ADDR_LSB +: 3] == ADDR_INDIV;
                        ld.cnt = 5'h00;
                        if (byte_in[CMD_READ_BIT]) begin // [R02]
                            ld.led_block = 1'b0; // [R13]
                            ld.state = ST_GAP;
                        end else if (byte_in[CMD_IDX_LSB +: 4] == IDX_RESET) begin
                            // special command is a single byte
                            ld.led_block = 1'b0; // [R13]
                            if (addr_match(byte_in[CMD_ADDR_LSB +: 3])) begin // [R28]
                                ld.cfg = CFG_RESET; // [R25]
                                ld.cfg_toggle = ~lq.cfg_toggle;
                                if (ack_due(byte_in[CMD_ADDR_LSB +: 3] == ADDR_INDIV, lq.cfg)) begin // [R26]
                                    ld.drive = 1'b0; // [R19]
                                    ld.drive_oe = 1'b1;
                                    ld.drive_active = 1'b1;
                                    ld.state = ST_ACK;
                                end else begin
                                    ld.state = ST_IDLE;
                                end
                            end else begin
                                ld.state = ST_IDLE;
                            end
                        end else begin
                            ld.state = ST_DATA; // [R05]
                        end
                    end
                end
                ST_DATA: begin
                    // count 0 is the data byte's own start bit
                    if (lq.cnt != 5'h00) begin
                        ld.shift = byte_in;
                    end
                    ld.cnt = lq.cnt + 5'h01;
                    if (lq.cnt == 5'(BYTE_BITS)) begin
                        ld.led_block = 1'b0; // [R13]
                        ld.cnt = 5'h00;
                        ld.state = ST_IDLE;
                        if (lq.hit) begin // [R28]
                            // register writes update the shadow here, once the whole command is in; the special command resets it in ST_CMD
                            unique case (lq.cmd[CMD_IDX_LSB +: 4])
                                IDX_CTRL0: ld.cfg.ctrl0 = byte_in[C0_WIDTH-1:0]; // [R25]
                                IDX_CTRL1: ld.cfg.ctrl1 = byte_in;
                                IDX_CTRL2: ld.cfg.power = byte_in[C2_POWER_LSB +: 4];
                                default: ld.cfg = lq.cfg;
                            endcase
                            ld.cfg_toggle = ~lq.cfg_toggle;
                            if (ack_due(lq.indiv, lq.cfg)) begin // [R26]
                                ld.drive = 1'b0; // [R19]
                                ld.drive_oe = 1'b1;
                                ld.drive_active = 1'b1;
                                ld.state = ST_ACK;
                            end
                        end
                    end
                end
                ST_ACK: begin
                    // the low pulse has stood one cycle; hand the line back
                    ld.drive = RX_REST_LEVEL;
                    ld.drive_oe = 1'b0;
                    ld.drive_active = 1'b0;
                    // the clock stops after a write, so this edge already belongs to the next command
                    ld.led_block = 1'b1; // [R12] [R14]
                    ld.cnt = 5'h00;
                    ld.state = ST_IDLE;
                    if (tx == TX_START_LEVEL) begin // [R01] [R10]
                        ld.state = ST_CMD;
                    end
                end
                ST_GAP: begin
                    ld.cnt = lq.cnt + 5'h01;
                    // photodiode is cut off for the whole response phase
                    ld.drive_active = 1'b1; // [R15]
                    ld.drive = RX_REST_LEVEL;
                    // a slave that was not addressed still cuts its photodiode but leaves the line undriven
                    ld.drive_oe = lq.hit; // [R16]
                    if (!tx) begin // [R21]
                        ld.drive_active = 1'b0;
                        ld.drive_oe = 1'b0;
                        ld.state = ST_IDLE;
                    end else if (lq.cnt == 5'(RESP_GAP - 4'h1)) begin // [R03]
                        ld.drive = lq.hit ? RX_START_LEVEL : RX_REST_LEVEL; // [R09] [R10]
                        ld.shift = read_value(lq.cmd[CMD_IDX_LSB +: 4], lq.cfg);
                        ld.cnt = 5'h00;
                        ld.state = ST_RESP;
                    end
                end
                ST_RESP: begin
                    // end of the read is taken from the write line, not from a count
                    if (!tx) begin // [R21]
                        ld.drive = RX_REST_LEVEL;
                        ld.drive_oe = 1'b0;
                        ld.drive_active = 1'b0;
                        ld.state = ST_IDLE;
                    end else if (lq.cnt < 5'(BYTE_BITS)) begin
                        ld.drive = lq.hit ? lq.shift[0] : RX_REST_LEVEL; // [R06] [R09]
                        ld.shift = {1'b0, lq.shift[7:1]};
                        ld.cnt = lq.cnt + 5'h01;
                    end else begin
                        ld.drive = RX_REST_LEVEL;
                    end
                end
                default: begin
                    ld.state = ST_IDLE;
                    ld.drive_active = 1'b0;
                    ld.drive_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge link_clk_i) begin
        lq <= ld;
    end

    // system domain: pick up a finished configuration once the toggle has crossed
    always_comb begin
        sd = sq;
        if (rst_i) begin
            sd.cfg = CFG_RESET;
            sd.toggle_seen = 1'b0;
        end else if (toggle_sync != sq.toggle_seen) begin
            sd.cfg = lq.cfg; // [R25]
            sd.toggle_seen = toggle_sync;
        end
    end

    always_ff @(posedge clk_i) begin
        sq <= sd;
    end

    // led follows the write line straight through; too fast to pass through flops
    assign ir_transmit_line_o = tx & ~lq.led_block & lq.cfg.ctrl0[C0_LED_BIT]; // [R11] [R12] [R13]

    // read line: link drive wins, otherwise the photodiode or the resting level
    always_comb begin
        if (lq.drive_active) begin
            rx_and_read_data_line_o = lq.drive; // [R09]
            rx_and_read_data_line_oe_o = lq.drive_oe; // [R16]
        end else begin
            // ack enable keeps the photodiode off the line at all times
            rx_and_read_data_line_o = lq.cfg.ctrl0[C0_ACK_PULSE_ENABLE_BIT] ? RX_REST_LEVEL : photo_sync; // [R19] [R22]
            rx_and_read_data_line_oe_o = lq.cfg.ctrl0[C0_OEN_BIT];
        end
    end

    assign power_mode_o = sq.cfg.ctrl0[C0_POWER_BIT];
    assign receiver_output_enable_o = sq.cfg.ctrl0[C0_OEN_BIT];
    assign led_enable_o = sq.cfg.ctrl0[C0_LED_BIT];
    assign ack_pulse_enable_o = sq.cfg.ctrl0[C0_ACK_PULSE_ENABLE_BIT];
    assign ir_mode_o = sq.cfg.ctrl1;
    assign tx_power_o = sq.cfg.power;

endmodule

// *** bench/irsc_slave_asserts.sv ***
// port checker of the control serial slave, bound to irsc_slave.
// assumes the serial clock stands still between transfers.
`timescale 1ns/10ps
module irsc_slave_asserts (
    // clocks and reset
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic link_clk_i,
    // link lines
    input wire logic tx_and_write_data_line_i,
    input wire logic ir_transmit_line_o,
    input wire logic rx_and_read_data_line_o,
    input wire logic rx_and_read_data_line_oe_o,
    // status
    input wire logic receiver_output_enable_o,
    input wire logic [7:0] ir_mode_o,
    input wire logic [3:0] tx_power_o,
    input wire logic link_ready_o
);
    // counts from reset, so it never trails the slave's own priming count
    logic [5:0] low_cnt_q;
    always_ff @(posedge link_clk_i) begin
        if (rst_i || tx_and_write_data_line_i) begin
            low_cnt_q <= 6'h00;
        end else if (low_cnt_q != 6'h3f) begin
            low_cnt_q <= low_cnt_q + 6'h01;
        end
    end
    property p_led_gate;
        @(posedge clk_i) disable iff (rst_i) ir_transmit_line_o |-> tx_and_write_data_line_i;
    endproperty
    a_led_gate: assert property (p_led_gate) else $error("led on with write line low");
    property p_prime_led;
        @(posedge clk_i) disable iff (rst_i) !link_ready_o |-> !ir_transmit_line_o;
    endproperty
    a_prime_led: assert property (p_prime_led) else $error("led on before priming");
    property p_reset_cfg;
        @(posedge clk_i) disable iff (rst_i)
            $fell(rst_i) |-> tx_power_o == 4'h7 && ir_mode_o == 8'h00 && !receiver_output_enable_o;
    endproperty
    a_reset_cfg: assert property (p_reset_cfg) else $error("config not default after reset");
    property p_cfg_quiet;
        @(posedge clk_i) disable iff (rst_i) !link_ready_o |=> $stable(ir_mode_o) && $stable(tx_power_o);
    endproperty
    a_cfg_quiet: assert property (p_cfg_quiet) else $error("config moved while link not ready");
    property p_prime_cnt;
        @(posedge link_clk_i) disable iff (rst_i) $rose(link_ready_o) |-> low_cnt_q >= 6'h1e;
    endproperty
    a_prime_cnt: assert property (p_prime_cnt) else $error("ready before priming done");
    property p_ready_hold;
        @(posedge link_clk_i) disable iff (rst_i) link_ready_o |=> link_ready_o;
    endproperty
    a_ready_hold: assert property (p_ready_hold) else $error("ready dropped");
    property p_resp_gap;
        @(posedge link_clk_i) disable iff (rst_i) $rose(rx_and_read_data_line_oe_o) && !receiver_output_enable_o
            |-> rx_and_read_data_line_o [*3] ##1 !rx_and_read_data_line_o;
    endproperty
    a_resp_gap: assert property (p_resp_gap) else $error("response start misplaced");
    property p_resp_oe;
        @(posedge link_clk_i) disable iff (rst_i) $rose(rx_and_read_data_line_oe_o) && !receiver_output_enable_o
            |-> rx_and_read_data_line_oe_o [*8];
    endproperty
    a_resp_oe: assert property (p_resp_oe) else $error("read line released in response");
    c_ready: cover property (@(posedge link_clk_i) $rose(link_ready_o));
    c_resp: cover property (@(posedge link_clk_i) $rose(rx_and_read_data_line_oe_o) && !receiver_output_enable_o);
    c_ack: cover property (@(posedge link_clk_i) rx_and_read_data_line_oe_o && !rx_and_read_data_line_o);
endmodule
bind irsc_slave irsc_slave_asserts i_irsc_slave_asserts (.clk_i, .rst_i, .link_clk_i, .tx_and_write_data_line_i,
    .ir_transmit_line_o, .rx_and_read_data_line_o, .rx_and_read_data_line_oe_o, .receiver_output_enable_o,
    .ir_mode_o, .tx_power_o, .link_ready_o);

// *** bench/irsc_master_model.sv ***
// master side of the control link: serial clock, write line, read-back sampling.
// assumes the slave samples on rising edges; the clock stands still between calls.
`timescale 1ns/10ps
module irsc_master_model (
    // link outputs
    output logic link_clk_o,
    output logic tx_o,
    // slave answers
    input wire logic rx_i,
    input wire logic oe_i,
    input wire logic led_i
);
    logic pre_rx, pre_oe, hi_rx, hi_oe, hi_led, led_start, cmd_led, oe_seen;
    logic [12:0] smp;
    initial begin
        link_clk_o = 1'b0;
        tx_o = 1'b0;
    end
    // odd split keeps the rising edges off the system clock edges
    task automatic tick();
        #23.9;
        pre_rx = oe_i ? rx_i : 1'b1;
        pre_oe = oe_i;
        link_clk_o = 1'b1;
        #12;
        hi_rx = oe_i ? rx_i : 1'b1;
        hi_oe = oe_i;
        hi_led = led_i;
        #12.1;
        link_clk_o = 1'b0;
    endtask
    task automatic idle(input logic v);
        tx_o = v;
    endtask
    task automatic prime(input int n);
        tx_o = 1'b0;
        repeat (n) tick();
    endtask
    task automatic send(input logic [7:0] b);
        tx_o = 1'b1;
        tick();
        led_start = hi_led;
        for (int i = 0; i < 8; i++) begin
            tx_o = b[i];
            tick();
        end
    endtask
    task automatic write(input logic [7:0] cmd, input logic [7:0] d);
        send(cmd);
        cmd_led = led_start;
        send(d);
        tx_o = 1'b0;
    endtask
    task automatic read(input logic [7:0] cmd);
        send(cmd);
        tx_o = 1'b1;
        oe_seen = 1'b0;
        for (int j = 0; j < 13; j++) begin
            if (j == 12) begin
                tx_o = 1'b0;
            end
            tick();
            smp[j] = pre_rx;
            if (j > 0) begin
                oe_seen = oe_seen | pre_oe;
            end
        end
    endtask
endmodule

// *** bench/irsc_slave_test.sv ***
// self-checking bench of the control serial slave with a master model.
// assumes the model owns the serial clock and the write line.
`timescale 1ns/10ps
module irsc_slave_test;
    import irsc_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ir_receive_line_i = 1'b1;
    logic link_clk_i, tx_and_write_data_line_i, ir_transmit_line_o, rx_and_read_data_line_o;
    logic rx_and_read_data_line_oe_o, power_mode_o, receiver_output_enable_o, led_enable_o;
    logic ack_pulse_enable_o, link_ready_o;
    logic [7:0] ir_mode_o;
    logic [3:0] tx_power_o;
    int n_mismatch = 0;
    int compares = 0;
    always #2.5 clk_i = ~clk_i;
    irsc_slave i_irsc_slave (.clk_i, .rst_i, .link_clk_i, .tx_and_write_data_line_i, .ir_transmit_line_o,
        .ir_receive_line_i, .rx_and_read_data_line_o, .rx_and_read_data_line_oe_o, .power_mode_o,
        .receiver_output_enable_o, .led_enable_o, .ack_pulse_enable_o, .ir_mode_o, .tx_power_o, .link_ready_o);
    irsc_master_model i_irsc_master_model (.link_clk_o(link_clk_i), .tx_o(tx_and_write_data_line_i),
        .rx_i(rx_and_read_data_line_o), .oe_i(rx_and_read_data_line_oe_o), .led_i(ir_transmit_line_o));
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic test_done();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // config lands a few system clocks after the link edge that ends the command
    task automatic wr(input logic [2:0] a, input logic [3:0] idx, input logic [7:0] d);
        i_irsc_master_model.write({idx, 1'b0, a}, d);
        cyc(8);
    endtask
    task automatic rd(input logic [2:0] a, input logic [3:0] idx);
        i_irsc_master_model.read({idx, 1'b1, a});
        cyc(8);
    endtask
    task automatic test_reset();
        chk("tx power", 8'h07, {4'h0, tx_power_o});
        chk("ir mode", 8'h00, ir_mode_o);
        chk("flags", 8'h00, {2'h0, power_mode_o, receiver_output_enable_o, led_enable_o, ack_pulse_enable_o,
            rx_and_read_data_line_oe_o, link_ready_o});
    endtask
    task automatic test_prime();
        i_irsc_master_model.prime(34);
        chk("link ready", 8'h01, {7'h00, link_ready_o});
    endtask
    task automatic test_rw();
        logic [3:0] idx [3] = '{4'h1, 4'h2, 4'h0};
        logic [7:0] dat [3] = '{8'ha5, 8'h30, 8'h05};
        for (int k = 0; k < 3; k++) begin
            wr(ADDR_INDIV, idx[k], dat[k]);
            rd(ADDR_INDIV, idx[k]);
            chk("read data", dat[k], i_irsc_master_model.smp[12:5]);
            chk("gap and start", 8'h07, {4'h0, i_irsc_master_model.smp[4:1]});
            chk("read oe", 8'h01, {7'h00, i_irsc_master_model.oe_seen});
        end
        chk("mode", 8'ha5, ir_mode_o);
        chk("power", 8'h03, {4'h0, tx_power_o});
        chk("ctrl0", 8'h05, {3'h0, ack_pulse_enable_o, 1'b0, led_enable_o, receiver_output_enable_o,
            power_mode_o});
    endtask
    task automatic test_addr();
        wr(ADDR_BCAST, 4'h1, 8'h5a);
        chk("bcast mode", 8'h5a, ir_mode_o);
        wr(3'h3, 4'h1, 8'h11);
        chk("foreign mode", 8'h5a, ir_mode_o);
        rd(3'h3, 4'h1);
        chk("foreign oe", 8'h00, {7'h00, i_irsc_master_model.oe_seen});
        chk("foreign data", 8'hff, i_irsc_master_model.smp[12:5]);
    endtask
    task automatic test_led();
        wr(ADDR_INDIV, 4'h2, 8'h50);
        chk("led in command", 8'h00, {7'h00, i_irsc_master_model.cmd_led});
        i_irsc_master_model.idle(1'b1);
        #1;
        chk("led after command", 8'h01, {7'h00, ir_transmit_line_o});
        i_irsc_master_model.idle(1'b0);
        i_irsc_master_model.tick();
        i_irsc_master_model.idle(1'b1);
        #1;
        chk("led after stray edge", 8'h00, {7'h00, ir_transmit_line_o});
        i_irsc_master_model.idle(1'b0);
        #1;
        chk("led at rest", 8'h00, {7'h00, ir_transmit_line_o});
    endtask
    task automatic test_ack();
        wr(ADDR_INDIV, 4'h0, 8'h16);
        @(posedge clk_i) ir_receive_line_i <= 1'b0;
        cyc(6);
        chk("photodiode cut", 8'h01, {7'h00, rx_and_read_data_line_o});
        wr(ADDR_INDIV, 4'h0, 8'h16);
        chk("ack pulse", 8'h02, {6'h00, i_irsc_master_model.hi_oe, i_irsc_master_model.hi_rx});
        wr(ADDR_BCAST, 4'h0, 8'h16);
        chk("bcast no ack", 8'h03, {6'h00, i_irsc_master_model.hi_oe, i_irsc_master_model.hi_rx});
        i_irsc_master_model.send({IDX_RESET, 1'b0, ADDR_INDIV});
        i_irsc_master_model.idle(1'b0);
        chk("special ack", 8'h02, {6'h00, i_irsc_master_model.hi_oe, i_irsc_master_model.hi_rx});
        cyc(8);
        chk("reset power", 8'h07, {4'h0, tx_power_o});
        chk("reset mode", 8'h00, ir_mode_o);
        @(posedge clk_i) ir_receive_line_i <= 1'b1;
    endtask
    // reset outlasts ten clocks so the link side sees a few serial edges too
    initial begin
        cyc(10);
        i_irsc_master_model.prime(4);
        @(posedge clk_i) rst_i <= 1'b0;
        cyc(2);
        test_reset();
        test_prime();
        test_rw();
        test_addr();
        test_led();
        test_ack();
        test_done();
    end
    initial begin
        #100000;
        n_mismatch++;
        test_done();
    end
endmodule
